// file: dcc_arbiter.sv
// fixed priority channel picker: high priority group first, then lowest number
`timescale 1ns/1ps
module dcc_arbiter (
	input  wire logic [31:0] pend,    // channels asking for service
	input  wire logic [31:0] prio,    // high priority attribute
	output logic             valid,   // some channel may be served
	output logic [4:0]       idx      // chosen channel number
);
	function automatic logic [4:0] first_set(input logic [31:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 31; i >= 0; i--) begin
			if (v[i]) r = 5'(i);
		end
		return r;
	endfunction : first_set

	wire logic [31:0] hi = pend & prio;

	// high group wins outright, so a busy low channel can starve; that is intended
	assign valid = |pend;
	assign idx   = (|hi) ? first_set(hi) : first_set(pend);
endmodule : dcc_arbiter

// file: dcc_mem_model.sv
// system memory and bus responder facing the dma channel controller
`timescale 1ns/1ps
module dcc_mem_model (
	input  wire logic        ref_clk,    // system clock
	input  wire logic        resetn,     // synchronous reset, active low
	input  wire logic        mem_valid,  // access pending
	input  wire logic        mem_we,     // access is a write
	input  wire logic [31:0] mem_addr,   // byte address
	input  wire logic [31:0] mem_wdata,  // write data
	input  wire logic [3:0]  lat,        // idle cycles before each ack
	input  wire logic        err_arm,    // fail every access while set
	output logic             mem_ack,    // access done
	output logic             mem_err,    // access failed
	output logic [31:0]      mem_rdata   // read data with ack
);
	logic [31:0] ram [0:1023]; // all of it is ram, task lists included
	logic [3:0]  wait_cnt;
	// ack after lat cycles; whole words only, the bench moves word items
	always @(posedge ref_clk) begin
		if (!resetn) begin
			mem_ack   <= 1'b0;
			mem_err   <= 1'b0;
			wait_cnt  <= 4'h0;
			mem_rdata <= 32'h00000000;
		end else if (mem_valid && !mem_ack && wait_cnt >= lat) begin
			mem_ack   <= 1'b1;
			mem_err   <= err_arm;
			wait_cnt  <= 4'h0;
			mem_rdata <= mem_we ? ~mem_rdata : ram[mem_addr[11:2]];
			if (mem_we && !err_arm)
				ram[mem_addr[11:2]] <= mem_wdata;
		end else begin
			mem_ack   <= 1'b0;
			mem_err   <= 1'b0;
			wait_cnt  <= (mem_valid && !mem_ack) ? wait_cnt + 4'h1 : 4'h0;
			mem_rdata <= ~mem_rdata; // a released bus never keeps its last value
		end
	end
endmodule : dcc_mem_model

// file: dcc_mem_port.sv
// single outstanding system memory access, held until the memory acknowledges
`timescale 1ns/1ps
module dcc_mem_port (
	input  wire logic              ref_clk,    // system clock
	input  wire logic              resetn,     // synchronous reset, active low
	input  wire logic              start,      // launch req, only while idle
	input  wire dcc_pkg::dcc_mreq_t req,       // access to launch
	output dcc_pkg::dcc_mreq_t     mem,        // access on the memory bus
	output logic                   mem_valid,  // access pending
	input  wire logic              mem_ack,    // memory took the access
	input  wire logic              mem_err,    // access failed, with mem_ack
	input  wire logic [31:0]       mem_rdata,  // read data, with mem_ack
	output logic                   done,       // access finished, one cycle
	output logic                   err,        // finished with error, one cycle
	output logic [31:0]            rdata       // captured read data
);
	// request stays up until acknowledged
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			mem_valid <= 1'b0;
			mem       <= '0;
			done      <= 1'b0;
			err       <= 1'b0;
			rdata     <= 32'h00000000;
		end else begin
			done <= mem_valid & mem_ack;
			err  <= mem_valid & mem_ack & mem_err;
			if (start) begin
				mem_valid <= 1'b1;
				mem       <= req;
			end else if (mem_ack) begin
				mem_valid <= 1'b0;
			end
			if (mem_valid & mem_ack) rdata <= mem_rdata;
		end
	end
endmodule : dcc_mem_port

// file: dcc_pkg.sv
// types shared by the dma channel controller modules
package dcc_pkg;
	typedef enum logic [2:0] {
		MODE_STOP = 3'h0, MODE_BASIC = 3'h1, MODE_AUTO = 3'h2, MODE_PINGPONG = 3'h3,
		MODE_MEM_SG = 3'h4, MODE_MEM_SG_ALT = 3'h5, MODE_PER_SG = 3'h6,
		MODE_PER_SG_ALT = 3'h7
	} dcc_mode_t;
	typedef enum logic [8:0] {
		ST_IDLE = 9'h001, ST_RD_SRC = 9'h002, ST_RD_DST = 9'h004, ST_RD_CTL = 9'h008,
		ST_XF_RD = 9'h010, ST_XF_WR = 9'h020, ST_WB_SRC = 9'h040, ST_WB_DST = 9'h080,
		ST_WB_CTL = 9'h100
	} dcc_state_t;
	// descriptor control word
	typedef struct packed {
		logic [1:0] dst_inc;
		logic [1:0] dst_size;
		logic [1:0] src_inc;
		logic [1:0] src_size;
		logic [5:0] rsvd_hi;
		logic [3:0] arb;
		logic [9:0] count;
		logic       rsvd_lo;
		dcc_mode_t  mode;
	} dcc_ctl_t;
	// one system memory access
	typedef struct packed {
		logic        we;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [1:0]  size;
	} dcc_mreq_t;
endpackage : dcc_pkg

// file: dcc_regs.svh
// register offsets, reset values and field limits of the dma channel controller
`ifndef DCC_REGS_SVH
`define DCC_REGS_SVH
`define DCC_OFS_CFG      8'h00
`define DCC_OFS_BASE     8'h04
`define DCC_OFS_ENA_SET  8'h08
`define DCC_OFS_ENA_CLR  8'h0C
`define DCC_OFS_PRIO_SET 8'h10
`define DCC_OFS_PRIO_CLR 8'h14
`define DCC_OFS_MASK_SET 8'h18
`define DCC_OFS_MASK_CLR 8'h1C
`define DCC_OFS_SWREQ    8'h20
`define DCC_OFS_ERR      8'h24
`define DCC_OFS_STAT     8'h28
`define DCC_OFS_ALT      8'h2C
`define DCC_BASE_LSB     10
`define DCC_RST_BASE     22'h000000
`define DCC_RST_VEC      32'h00000000
`define DCC_ARB_MAX      4'hA
`endif

// file: dcc_top.sv
// dma channel controller: 32 channels, descriptors fetched from a table in memory
// Summary of operation
// - no transfers before global enable; serving stops once globally disabled
// - programmable table base; descriptors are read relative to it
// - per-channel attribute flags individually set, cleared and read back
// - descriptor control word gives item size and address increments
// - channel enable clears itself when a basic or auto transfer completes
// - software may clear any channel enable at any time
// - remaining count reads zero after completion
// - mode field becomes stopped after a transfer finishes
// - per-channel enabled status is readable
// - software request starts a channel without peripheral request
// - controller interrupt only for software transfer completion and errors
// - peripheral channel completion goes to that peripheral's own line, in basic, auto and ping-pong modes only
// - completion interrupts clear themselves, no acknowledge needed
// - error flag and its interrupt hold until software clears them
// - basic and auto modes use only the primary descriptor
// - ping-pong and scatter-gather also use the alternate descriptor
// - task lists must sit in ram, the controller cannot fetch flash
// - thirty-two independent channels, numbered 0 to 31
// - one descriptor moves 1 to 1024 items
// - arbitration size is a power of two from 1 to 1024
// - basic mode pauses while the peripheral request is low
`timescale 1ns/1ps
`include "dcc_regs.svh"
module dcc_top (
	input  wire logic        ref_clk,      // 10 MHz system clock
	input  wire logic        resetn,       // synchronous reset, active low
	input  wire logic [7:0]  reg_addr,     // register byte address
	input  wire logic [31:0] reg_wdata,    // register write data
	input  wire logic        reg_wr,       // write strobe
	input  wire logic        reg_rd,       // read strobe
	output logic [31:0]      reg_rdata,    // read data, cycle after reg_rd
	input  wire logic [31:0] periph_req,   // peripheral requests, one per channel
	output logic             mem_valid,    // memory access pending
	output logic             mem_we,       // access is a write
	output logic [31:0]      mem_addr,     // byte address
	output logic [31:0]      mem_wdata,    // write data
	output logic [1:0]       mem_size,     // 0 byte, 1 half, 2 word
	input  wire logic        mem_ack,      // access finished
	input  wire logic        mem_err,      // access failed
	input  wire logic [31:0] mem_rdata,    // read data
	output logic             sw_irq,       // software transfer done, pulse
	output logic             err_irq,      // bus error, held
	output logic [31:0]      periph_done   // peripheral channel done, pulses
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	// descriptor word address: table base, index, word
	function automatic logic [31:0] desc_addr(input logic [21:0] b, input logic [5:0] i,
			input logic [1:0] w);
		return {b, i, w, 2'b00};
	endfunction : desc_addr

	// advance an address by the increment code
	function automatic logic [31:0] step(input logic [31:0] a, input logic [1:0] inc);
		case (inc)
			2'h0:    return 32'(a + 32'h1);
			2'h1:    return 32'(a + 32'h2);
			2'h2:    return 32'(a + 32'h4);
			default: return a;
		endcase
	endfunction : step

	function automatic dcc_pkg::dcc_mreq_t mk(input logic we, input logic [31:0] a,
			input logic [31:0] d, input logic [1:0] s);
		dcc_pkg::dcc_mreq_t r;
		r.we    = we;
		r.addr  = a;
		r.wdata = d;
		r.size  = s;
		return r;
	endfunction : mk

	// software visible state
	logic        gen;
	logic [21:0] base;
	logic [31:0] chan_en, prio, rmask, swreq, alt_sel;
	logic        err_flag;

	// engine state
	dcc_pkg::dcc_state_t state, next_state;
	logic [4:0]          cur;
	logic                cur_alt;
	logic [31:0]         src, dst;
	dcc_pkg::dcc_ctl_t   ctl;
	logic [10:0]         beats;
	logic                cmpl;

	// memory port hookup
	logic               mp_start, mp_done, mp_err;
	dcc_pkg::dcc_mreq_t mp_req, mp_mem;
	logic [31:0]        mp_rdata;
	logic               gnt_valid;
	logic [4:0]         gnt_idx;

	// register write decode
	wire logic wr_cfg  = reg_wr && reg_addr == `DCC_OFS_CFG;
	wire logic wr_base = reg_wr && reg_addr == `DCC_OFS_BASE;
	wire logic wr_err  = reg_wr && reg_addr == `DCC_OFS_ERR && reg_wdata[0];
	wire logic [31:0] ena_set  = (reg_wr && reg_addr == `DCC_OFS_ENA_SET)  ? reg_wdata : '0;
	wire logic [31:0] ena_clr  = (reg_wr && reg_addr == `DCC_OFS_ENA_CLR)  ? reg_wdata : '0;
	wire logic [31:0] prio_set = (reg_wr && reg_addr == `DCC_OFS_PRIO_SET) ? reg_wdata : '0;
	wire logic [31:0] prio_clr = (reg_wr && reg_addr == `DCC_OFS_PRIO_CLR) ? reg_wdata : '0;
	wire logic [31:0] mask_set = (reg_wr && reg_addr == `DCC_OFS_MASK_SET) ? reg_wdata : '0;
	wire logic [31:0] mask_clr = (reg_wr && reg_addr == `DCC_OFS_MASK_CLR) ? reg_wdata : '0;
	wire logic [31:0] sw_set   = (reg_wr && reg_addr == `DCC_OFS_SWREQ)    ? reg_wdata : '0;

	// channel service request; software request ignores the request mask
	wire logic [31:0] pend = chan_en & (swreq | (periph_req & ~rmask));

	dcc_arbiter u_arb (
		.pend  (pend),
		.prio  (prio),
		.valid (gnt_valid),
		.idx   (gnt_idx)
	);

	// transfer bookkeeping
	wire logic [31:0] cur_oh    = 32'h00000001 << cur;
	wire logic [10:0] beats_inc = 11'(beats + 11'h001);
	wire logic [10:0] burst_len = 11'h001 << ctl.arb;
	wire logic        last_item = ctl.count == 10'h000;
	wire logic        cur_sw    = |(swreq & cur_oh);
	wire logic        cur_preq  = |(periph_req & cur_oh);
	wire logic        cur_en    = |(chan_en & cur_oh);
	wire logic        req_pause = ctl.mode == dcc_pkg::MODE_BASIC && !cur_sw && !cur_preq;
	wire logic        stop_burst = last_item || beats_inc == burst_len || !gen || !cur_en
		|| req_pause;

	// stopped control word written back at completion
	dcc_pkg::dcc_ctl_t ctl_wb;
	always_comb begin
		ctl_wb = ctl;
		if (cmpl) begin
			ctl_wb.mode  = dcc_pkg::MODE_STOP;
			ctl_wb.count = 10'h000;
		end
	end

	// completion events and what they do
	wire logic ev_err   = mp_done && mp_err;
	wire logic ev_done  = mp_done && !mp_err && state == dcc_pkg::ST_WB_CTL && cmpl;
	wire logic ev_stop  = mp_done && !mp_err && state == dcc_pkg::ST_RD_CTL
		&& mp_rdata[2:0] == dcc_pkg::MODE_STOP;
	wire logic chained  = ctl.mode >= dcc_pkg::MODE_PINGPONG;
	wire logic done_irq = ev_done && ctl.mode <= dcc_pkg::MODE_PINGPONG;
	wire logic hw_dis   = ev_err || ev_stop || (ev_done && !chained);
	wire logic [31:0] dis_mask  = hw_dis ? cur_oh : '0;
	wire logic [31:0] sw_finish = (ev_done || ev_err || ev_stop) ? cur_oh : '0;

	// sequencer: fetch descriptor, move items, write back
	always_comb begin
		next_state = state;
		mp_start   = 1'b0;
		mp_req     = '0;
		case (state)
			dcc_pkg::ST_IDLE: begin
				if (gen && gnt_valid) begin
					mp_start   = 1'b1;
					mp_req     = mk(1'b0, desc_addr(base, {alt_sel[gnt_idx], gnt_idx}, 2'h0),
						32'h00000000, 2'h2);
					next_state = dcc_pkg::ST_RD_SRC;
				end
			end
			dcc_pkg::ST_RD_SRC: begin
				if (mp_done) begin
					mp_start   = 1'b1;
					mp_req     = mk(1'b0, desc_addr(base, {cur_alt, cur}, 2'h1), 32'h0, 2'h2);
					next_state = dcc_pkg::ST_RD_DST;
				end
			end
			dcc_pkg::ST_RD_DST: begin
				if (mp_done) begin
					mp_start   = 1'b1;
					mp_req     = mk(1'b0, desc_addr(base, {cur_alt, cur}, 2'h2), 32'h0, 2'h2);
					next_state = dcc_pkg::ST_RD_CTL;
				end
			end
			dcc_pkg::ST_RD_CTL: begin
				if (ev_stop) begin
					next_state = dcc_pkg::ST_IDLE;
				end else if (mp_done) begin
					mp_start   = 1'b1;
					mp_req     = mk(1'b0, src, 32'h0, mp_rdata[25:24]);
					next_state = dcc_pkg::ST_XF_RD;
				end
			end
			dcc_pkg::ST_XF_RD: begin
				if (mp_done) begin
					mp_start   = 1'b1;
					mp_req     = mk(1'b1, dst, mp_rdata, ctl.dst_size);
					next_state = dcc_pkg::ST_XF_WR;
				end
			end
			dcc_pkg::ST_XF_WR: begin
				if (mp_done) begin
					mp_start = 1'b1;
					if (stop_burst) begin
						mp_req     = mk(1'b1, desc_addr(base, {cur_alt, cur}, 2'h0),
							step(src, ctl.src_inc), 2'h2);
						next_state = dcc_pkg::ST_WB_SRC;
					end else begin
						mp_req     = mk(1'b0, step(src, ctl.src_inc), 32'h0, ctl.src_size);
						next_state = dcc_pkg::ST_XF_RD;
					end
				end
			end
			dcc_pkg::ST_WB_SRC: begin
				if (mp_done) begin
					mp_start   = 1'b1;
					mp_req     = mk(1'b1, desc_addr(base, {cur_alt, cur}, 2'h1), dst, 2'h2);
					next_state = dcc_pkg::ST_WB_DST;
				end
			end
			dcc_pkg::ST_WB_DST: begin
				if (mp_done) begin
					mp_start   = 1'b1;
					mp_req     = mk(1'b1, desc_addr(base, {cur_alt, cur}, 2'h2), ctl_wb, 2'h2);
					next_state = dcc_pkg::ST_WB_CTL;
				end
			end
			dcc_pkg::ST_WB_CTL: begin
				if (mp_done) next_state = dcc_pkg::ST_IDLE;
			end
			default: next_state = dcc_pkg::ST_IDLE;
		endcase
		// a failed access abandons the channel at once
		if (ev_err) begin
			mp_start   = 1'b0;
			next_state = dcc_pkg::ST_IDLE;
		end
	end

	dcc_mem_port u_mp (
		.ref_clk   (ref_clk),
		.resetn    (resetn),
		.start     (mp_start),
		.req       (mp_req),
		.mem       (mp_mem),
		.mem_valid (mem_valid),
		.mem_ack   (mem_ack),
		.mem_err   (mem_err),
		.mem_rdata (mem_rdata),
		.done      (mp_done),
		.err       (mp_err),
		.rdata     (mp_rdata)
	);
	assign mem_we    = mp_mem.we;
	assign mem_addr  = mp_mem.addr;
	assign mem_wdata = mp_mem.wdata;
	assign mem_size  = mp_mem.size;

	// engine datapath
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			state   <= dcc_pkg::ST_IDLE;
			cur     <= 5'h00;
			cur_alt <= 1'b0;
			src     <= 32'h00000000;
			dst     <= 32'h00000000;
			ctl     <= '0;
			beats   <= 11'h000;
			cmpl    <= 1'b0;
		end else begin
			state <= next_state;
			if (state == dcc_pkg::ST_IDLE) begin
				cur     <= gnt_idx;
				cur_alt <= alt_sel[gnt_idx];
				beats   <= 11'h000;
				cmpl    <= 1'b0;
			end
			if (mp_done && !mp_err) begin
				case (state)
					dcc_pkg::ST_RD_SRC: src <= mp_rdata;
					dcc_pkg::ST_RD_DST: dst <= mp_rdata;
					dcc_pkg::ST_RD_CTL: ctl <= mp_rdata;
					dcc_pkg::ST_XF_WR: begin
						src   <= step(src, ctl.src_inc);
						dst   <= step(dst, ctl.dst_inc);
						beats <= beats_inc;
						cmpl  <= last_item;
						if (!last_item) ctl.count <= 10'(ctl.count - 10'h001);
					end
					default: ;
				endcase
			end
		end
	end

	// software state; a register set in the same cycle as a hardware clear wins
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			gen      <= 1'b0;
			base     <= `DCC_RST_BASE;
			chan_en  <= `DCC_RST_VEC;
			prio     <= `DCC_RST_VEC;
			rmask    <= `DCC_RST_VEC;
			swreq    <= `DCC_RST_VEC;
			alt_sel  <= `DCC_RST_VEC;
			err_flag <= 1'b0;
		end else begin
			if (wr_cfg) gen <= reg_wdata[0];
			if (wr_base) base <= reg_wdata[31:`DCC_BASE_LSB];
			chan_en  <= (chan_en & ~ena_clr & ~dis_mask) | ena_set;
			prio     <= (prio & ~prio_clr) | prio_set;
			rmask    <= (rmask & ~mask_clr) | mask_set;
			swreq    <= (swreq & ~sw_finish) | sw_set;
			err_flag <= (err_flag & ~wr_err) | ev_err;
			if (ev_done) alt_sel[cur] <= chained ? ~cur_alt : 1'b0;
		end
	end

	// completion pulses last one cycle, so only err_irq, which holds, needs acknowledging
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			sw_irq      <= 1'b0;
			periph_done <= 32'h00000000;
			err_irq     <= 1'b0;
		end else begin
			sw_irq      <= done_irq && cur_sw;
			periph_done <= (done_irq && !cur_sw) ? cur_oh : '0;
			err_irq     <= (err_flag & ~wr_err) | ev_err;
		end
	end

	// read data: unmapped offsets answer zero
	logic [31:0] rd_mux;
	always_comb begin
		case (reg_addr)
			`DCC_OFS_CFG:      rd_mux = {31'h0, gen};
			`DCC_OFS_BASE:     rd_mux = {base, 10'h000};
			`DCC_OFS_ENA_SET,
			`DCC_OFS_ENA_CLR:  rd_mux = chan_en;
			`DCC_OFS_PRIO_SET,
			`DCC_OFS_PRIO_CLR: rd_mux = prio;
			`DCC_OFS_MASK_SET,
			`DCC_OFS_MASK_CLR: rd_mux = rmask;
			`DCC_OFS_SWREQ:    rd_mux = swreq;
			`DCC_OFS_ERR:      rd_mux = {31'h0, err_flag};
			`DCC_OFS_STAT:     rd_mux = {15'h0, state != dcc_pkg::ST_IDLE, cur_alt, cur,
				ctl.count};
			`DCC_OFS_ALT:      rd_mux = alt_sel;
			default:           rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) reg_rdata <= 32'h00000000;
		else reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
	end

	a_idle_when_off: assert property (
		state == dcc_pkg::ST_IDLE && !gen |=> state == dcc_pkg::ST_IDLE)
		else $error("engine left idle while globally disabled");
	a_fetch_base_addr: assert property (
		state == dcc_pkg::ST_IDLE && mp_start |=> mem_valid
		&& mem_addr == {base, alt_sel[cur], cur, 4'h0})
		else $error("descriptor fetch not at table base");
	a_done_clears_en: assert property (
		ev_done && !chained && !(|(ena_set & cur_oh)) |=> !(|(chan_en & $past(cur_oh))))
		else $error("enable not cleared at completion");
	a_sw_clear_en: assert property (
		|ena_clr && !(|ena_set) |=> (chan_en & $past(ena_clr)) == 32'h0)
		else $error("software disable ignored");
	a_stop_writeback: assert property (
		state == dcc_pkg::ST_WB_DST && mp_start && cmpl
		|-> mp_req.wdata[2:0] == 3'h0 && mp_req.wdata[13:4] == 10'h000)
		else $error("completion did not write stopped mode and zero count");
	a_sw_irq_cause: assert property (
		sw_irq |-> $past(ev_done) && $past(cur_sw))
		else $error("controller interrupt without software completion");
	a_periph_irq: assert property (
		|periph_done |-> $past(ev_done) && !$past(cur_sw) && periph_done == $past(cur_oh))
		else $error("peripheral done on wrong line");
	a_irq_one_cycle: assert property (
		sw_irq |=> !sw_irq)
		else $error("completion interrupt did not self clear");
	a_err_holds: assert property (
		err_irq && !wr_err |=> err_irq [*2] or (err_irq ##1 !err_irq && $past(wr_err)))
		else $error("error flag dropped without clear");
	a_alt_modes_only: assert property (
		ev_done && ctl.mode <= dcc_pkg::MODE_AUTO |=> !alt_sel[$past(cur)])
		else $error("basic or auto left alternate selected");
	a_basic_pause: assert property (
		state == dcc_pkg::ST_XF_WR && mp_done && !mp_err && req_pause
		|=> state == dcc_pkg::ST_WB_SRC)
		else $error("basic mode kept moving without request");
endmodule : dcc_top

// file: dcc_top_tb.sv
// self-checking bench for the dma channel controller
`timescale 1ns/1ps
module dcc_top_tb;
	localparam logic [31:0] TBL = 32'h00000400; // 1024 bytes, aligned
	logic        ref_clk    = 1'b0;
	logic        resetn     = 1'b0;
	logic [7:0]  reg_addr   = 8'h00;
	logic [31:0] reg_wdata  = 32'h00000000;
	logic        reg_wr     = 1'b0;
	logic        reg_rd     = 1'b0;
	logic [31:0] periph_req = 32'h00000000;
	logic [3:0]  lat        = 4'h0;
	logic        err_arm    = 1'b0;
	logic [31:0] reg_rdata, mem_addr, mem_wdata, mem_rdata, periph_done;
	logic        mem_valid, mem_we, mem_ack, mem_err, sw_irq, err_irq;
	logic [1:0]  mem_size;
	int          miscompares = 0, cmp_count = 0, sw_cnt = 0, pd_cnt = 0;
	int          acc_cnt = 0, alt_hits = 0, size_bad = 0;

	dcc_top u_dut (.ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.periph_req, .mem_valid, .mem_we, .mem_addr, .mem_wdata, .mem_size, .mem_ack,
		.mem_err, .mem_rdata, .sw_irq, .err_irq, .periph_done);
	dcc_mem_model u_mem (.ref_clk, .resetn, .mem_valid, .mem_we, .mem_addr, .mem_wdata,
		.lat, .err_arm, .mem_ack, .mem_err, .mem_rdata);

	always #50 ref_clk = ~ref_clk;

	// count interrupt pulses, finished accesses, alternate touches and non-word accesses
	always @(posedge ref_clk) begin
		if (sw_irq) sw_cnt <= sw_cnt + 1;
		if (mem_valid && mem_ack && mem_size != 2'h2) size_bad <= size_bad + 1;
		if (periph_done[3]) pd_cnt <= pd_cnt + 1;
		if (mem_valid && mem_ack) acc_cnt <= acc_cnt + 1;
		if (mem_valid && mem_ack && mem_addr[11:9] == 3'h3) alt_hits <= alt_hits + 1;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 check(reg_rdata, exp);
	endtask : rdchk

	// word items; inc packs dst and src increment codes
	function automatic logic [31:0] ctl(input logic [3:0] inc, input logic [3:0] arb,
		input logic [9:0] n, input logic [2:0] m);
		return {inc[3:2], 2'h2, inc[1:0], 2'h2, 6'h00, arb, n, 1'b0, m};
	endfunction : ctl

	function automatic logic [31:0] w(input int i, input int k);
		return u_mem.ram[256 + i * 4 + k];
	endfunction : w

	task automatic desc(input int i, input logic [31:0] s, input logic [31:0] d,
		input logic [31:0] c);
		u_mem.ram[256 + i * 4]     = s;
		u_mem.ram[256 + i * 4 + 1] = d;
		u_mem.ram[256 + i * 4 + 2] = c;
	endtask : desc

	task automatic wait_up(ref int c, input int n);
		for (int i = 0; i < 2000 && c < n; i++) @(posedge ref_clk);
	endtask : wait_up

	task automatic summarize;
		$display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : summarize

	// a hang is cut short well past the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		summarize();
	end

	initial begin
		for (int k = 0; k < 4; k++) u_mem.ram[k] = 32'hA5A50000 + k;
		repeat (16) @(posedge ref_clk);
		resetn <= 1'b1;
		rdchk(8'h00, 32'h00000000);
		rdchk(8'h08, 32'h00000000);
		rdchk(8'hFC, 32'h00000000);
		for (int k = 0; k < 2; k++) begin
			wr(8'h10 + 8'(8 * k), 32'h000000F0);
			wr(8'h14 + 8'(8 * k), 32'h00000030);
			rdchk(8'h10 + 8'(8 * k), 32'h000000C0);
			wr(8'h14 + 8'(8 * k), 32'hFFFFFFFF);
		end
		$display("test reset and attributes done");
		// auto transfer held back until the global enable, two bursts of two
		wr(8'h04, TBL | 32'h000003FF);
		rdchk(8'h04, TBL);
		desc(0, 32'h00000000, 32'h00000100, ctl(4'hA, 4'h1, 10'h003, 3'h2));
		wr(8'h08, 32'h00000001);
		wr(8'h20, 32'h00000001);
		repeat (40) @(posedge ref_clk);
		check(acc_cnt, 0);
		wr(8'h00, 32'h00000001);
		wait_up(sw_cnt, 1);
		check(sw_cnt, 1);
		for (int k = 0; k < 4; k++) check(u_mem.ram[64 + k], 32'hA5A50000 + k);
		check(acc_cnt, 20);
		check(w(0, 0), 32'h00000010);
		check(w(0, 2), ctl(4'hA, 4'h1, 10'h000, 3'h0));
		rdchk(8'h08, 32'h00000000);
		check(alt_hits, 0);
		$display("test auto transfer done");
		// ping-pong on channel 5: primary then alternate, fixed source address
		desc(5, 32'h00000000, 32'h00000200, ctl(4'hB, 4'h0, 10'h000, 3'h3));
		desc(37, 32'h00000004, 32'h00000204, ctl(4'hB, 4'h0, 10'h000, 3'h3));
		wr(8'h08, 32'h00000020);
		wr(8'h20, 32'h00000020);
		wait_up(sw_cnt, 2);
		check(u_mem.ram[128], 32'hA5A50000);
		rdchk(8'h2C, 32'h00000020);
		rdchk(8'h08, 32'h00000020);
		wr(8'h20, 32'h00000020);
		wait_up(sw_cnt, 3);
		check(u_mem.ram[129], 32'hA5A50001);
		check(w(5, 0), 32'h00000000);
		// a third request finds the primary stopped: channel drops, request clears
		wr(8'h20, 32'h00000020);
		repeat (30) @(posedge ref_clk);
		rdchk(8'h08, 32'h00000000);
		rdchk(8'h20, 32'h00000000);
		wr(8'h08, 32'h00000020);
		wr(8'h0C, 32'h00000020);
		rdchk(8'h08, 32'h00000000);
		$display("test ping-pong done");
		// basic peripheral channel 3 pauses while its request is low
		u_mem.ram[193] = 32'h00000000;
		desc(3, 32'h00000000, 32'h00000300, ctl(4'hA, 4'h0, 10'h001, 3'h1));
		wr(8'h08, 32'h00000008);
		periph_req <= 32'h00000008;
		for (int i = 0; i < 500 && u_mem.ram[192] !== 32'hA5A50000; i++) @(posedge ref_clk);
		periph_req <= 32'h00000000;
		repeat (40) @(posedge ref_clk);
		check(u_mem.ram[193], 32'h00000000);
		rdchk(8'h08, 32'h00000008);
		// a masked request is ignored until the mask is lifted
		wr(8'h18, 32'h00000008);
		periph_req <= 32'h00000008;
		repeat (20) @(posedge ref_clk);
		check(u_mem.ram[193], 32'h00000000);
		wr(8'h1C, 32'h00000008);
		wait_up(pd_cnt, 1);
		periph_req <= 32'h00000000;
		check(u_mem.ram[193], 32'hA5A50001);
		check(pd_cnt, 1);
		check(sw_cnt, 3);
		$display("test peripheral pause done");
		// slow memory failing the descriptor fetch of channel 2
		lat     <= 4'h3;
		err_arm <= 1'b1;
		desc(2, 32'h00000000, 32'h00000380, ctl(4'hA, 4'h0, 10'h000, 3'h2));
		wr(8'h08, 32'h00000004);
		wr(8'h20, 32'h00000004);
		for (int i = 0; i < 500 && err_irq !== 1'b1; i++) @(posedge ref_clk);
		err_arm <= 1'b0;
		repeat (20) @(posedge ref_clk);
		check({31'h00000000, err_irq}, 32'h00000001);
		rdchk(8'h24, 32'h00000001);
		rdchk(8'h08, 32'h00000000);
		wr(8'h24, 32'h00000001);
		rdchk(8'h24, 32'h00000000);
		check({31'h00000000, err_irq}, 32'h00000000);
		check(sw_cnt, 3);
		check(size_bad, 0);
		$display("test bus error done");
		summarize();
	end
endmodule : dcc_top_tb
